// ---- hw/sbc_regs_pkg.sv ----
package sbc_regs_pkg;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] BIT_CNT_FULL = 5'h10;
  localparam logic [4:0] BIT_CNT_OVER = 5'h11;
  localparam logic [4:0] BIT_CNT_ADDR = 5'h07;

  // ----------------------------------------------------------------
  // Register addresses (7-bit)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_WAKE_TIMER = 7'h0c;
  localparam logic [6:0] ADDR_SCRATCH    = 7'h1e;
  localparam logic [6:0] ADDR_SUPPLY     = 7'h41;
  localparam logic [6:0] ADDR_THERMAL    = 7'h42;
  localparam logic [6:0] ADDR_DEVICE     = 7'h43;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SUP_POR        = 7;
  localparam int SUP_LIN_LOW    = 6;
  localparam int SUP_MAIN_HIGH  = 5;
  localparam int SUP_AUX_HOT    = 4;
  localparam int SUP_AUX_LOW    = 3;
  localparam int SUP_MAIN_SHORT = 2;
  localparam int SUP_MAIN_LOW   = 0;
  localparam int TH_STAGE_TWO   = 2;
  localparam int TH_STAGE_ONE   = 1;
  localparam int TH_PREWARN     = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SCRATCH_RST     = 8'h00;
  localparam logic [7:0] SUPPLY_POR_RST  = 8'h80;
  localparam logic [7:0] SUPPLY_SOFT_KEEP = 8'h80;
  localparam logic [7:0] SUPPLY_MASK     = 8'hfd;
  localparam logic [2:0] THERMAL_RST     = 3'h0;
  localparam logic [1:0] CAUSE_CLEARED   = 2'h0;
  localparam logic [1:0] CAUSE_FAILURE   = 2'h1;
  localparam logic [1:0] CAUSE_SLEEP     = 2'h2;
  localparam logic [1:0] WD_CNT_RST      = 2'h0;
  localparam logic [1:0] WD_CNT_MAX      = 2'h2;

  typedef enum logic [2:0] {
    WAKE_P_10MS     = 3'b000,
    WAKE_P_20MS     = 3'b001,
    WAKE_P_50MS     = 3'b010,
    WAKE_P_100MS    = 3'b011,
    WAKE_P_200MS    = 3'b100,
    WAKE_P_1S       = 3'b101,
    WAKE_P_2S       = 3'b110,
    WAKE_P_RESERVED = 3'b111
  } wake_period_t;

  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b000,
    MODE_STOP     = 3'b001,
    MODE_SLEEP    = 3'b010,
    MODE_RESTART  = 3'b011,
    MODE_FAILSAFE = 3'b100
  } mode_t;

endpackage

// ---- hw/sbc_status_register_bank.sv ----
module sbc_status_register_bank (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       spi_clk,
  input  wire logic                       spi_cs_b,
  input  wire logic                       spi_mosi,
  output logic                            spi_miso,
  output logic                            spi_miso_oe,
  input  wire sbc_regs_pkg::mode_t        sbc_mode,
  input  wire logic                       soft_reset,
  input  wire logic                       restart_enter,
  input  wire logic                       wake_from_sleep,
  input  wire logic                       wake_from_failsafe,
  input  wire logic                       main_rail_on,
  input  wire logic                       aux_rail_on,
  input  wire logic                       lin_active,
  input  wire logic                       main_rail_low,
  input  wire logic                       main_rail_shorted,
  input  wire logic                       main_rail_high,
  input  wire logic                       aux_rail_low,
  input  wire logic                       aux_rail_hot,
  input  wire logic                       lin_supply_low,
  input  wire logic                       thermal_stage_two,
  input  wire logic                       thermal_stage_one,
  input  wire logic                       thermal_prewarn,
  input  wire logic                       reset_pin_stuck_high,
  input  wire logic                       failsafe_input_error,
  input  wire logic                       watchdog_fail,
  input  wire logic                       watchdog_good_trigger,
  input  wire logic                       fail_outputs_active,
  input  wire logic                       overvoltage_restart_enable,
  output sbc_regs_pkg::wake_period_t      wake_timer_period,
  output logic                            force_failsafe
);
  import sbc_regs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic         sclk_s1;
    logic         sclk_s2;
    logic         sclk_q;
    logic         cs_s1;
    logic         cs_s2;
    logic         cs_q;
    logic         mosi_s1;
    logic         mosi_s2;
    logic [4:0]   bit_cnt;
    logic [15:0]  rx_sh;
    logic [7:0]   tx_sh;
    logic         miso;
    logic         miso_oe;
    wake_period_t period;
    logic [7:0]   scratch_value;
    logic [7:0]   supply;
    logic [2:0]   thermal;
    logic [1:0]   restart_cause;
    logic         pin_stuck;
    logic         fsi_error;
    logic [1:0]   watchdog_fail_count;
    logic         bad_command;
    logic         fail_outputs_on;
    logic         fail_pending;
    logic         thermal_stage_two_q;
    logic         force_fs;
  } state_t;

  localparam state_t ST_RESET = '{
    cs_s1:         1'b1,
    cs_s2:         1'b1,
    cs_q:          1'b1,
    period:        WAKE_P_10MS,
    scratch_value: SCRATCH_RST,
    supply:        SUPPLY_POR_RST,
    thermal:       THERMAL_RST,
    restart_cause: CAUSE_CLEARED,
    watchdog_fail_count: WD_CNT_RST,
    default:       '0
  };

  state_t st_r;
  state_t st_nxt;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [6:0] a);
    is_mapped = (a == ADDR_WAKE_TIMER) || (a == ADDR_SCRATCH) ||
                (a == ADDR_SUPPLY) || (a == ADDR_THERMAL) ||
                (a == ADDR_DEVICE);
  endfunction

  function automatic logic [7:0] dev_byte(input state_t s);
    dev_byte = {s.restart_cause, s.pin_stuck, s.fsi_error,
                s.watchdog_fail_count, s.bad_command,
                s.fail_outputs_on};
  endfunction

  function automatic logic [7:0] rd_byte(input state_t s,
                                         input logic [6:0] a);
    case (a)
      ADDR_WAKE_TIMER: rd_byte = {5'h00, s.period};
      ADDR_SCRATCH:    rd_byte = s.scratch_value;
      ADDR_SUPPLY:     rd_byte = s.supply & SUPPLY_MASK;
      ADDR_THERMAL:    rd_byte = {5'h00, s.thermal};
      ADDR_DEVICE:     rd_byte = dev_byte(s);
      default:         rd_byte = 8'h00;
    endcase
  endfunction

  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_start;
  logic        cs_end;
  logic [15:0] rx_next;
  logic [6:0]  f_addr;
  logic        f_rw;
  logic [7:0]  f_data;
  logic        frame_ok;
  logic        fail_now;

  // Edges are taken on the second and third stages only, so the
  // first synchroniser stage feeds nothing but the second.
  assign sclk_rise = st_r.sclk_s2 & ~st_r.sclk_q & ~st_r.cs_s2;
  assign sclk_fall = ~st_r.sclk_s2 & st_r.sclk_q & ~st_r.cs_s2;
  assign cs_start  = ~st_r.cs_s2 & st_r.cs_q;
  assign cs_end    = st_r.cs_s2 & ~st_r.cs_q;
  assign rx_next   = {st_r.mosi_s2, st_r.rx_sh[15:1]};
  assign f_addr    = st_r.rx_sh[6:0];
  assign f_rw      = st_r.rx_sh[7];
  assign f_data    = st_r.rx_sh[15:8];
  assign frame_ok  = cs_end && (st_r.bit_cnt == BIT_CNT_FULL) &&
                     is_mapped(f_addr);
  assign fail_now  = watchdog_fail | thermal_stage_two | main_rail_low |
                     (main_rail_high & overvoltage_restart_enable);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic clr_sup;
    logic clr_th;
    logic clr_dev;
    logic [7:0] sup_set;
    clr_sup = 1'b0;
    clr_th  = 1'b0;
    clr_dev = 1'b0;
    sup_set = 8'h00;
    st_nxt  = st_r;
    st_nxt.sclk_s1 = spi_clk;
    st_nxt.sclk_s2 = st_r.sclk_s1;
    st_nxt.sclk_q  = st_r.sclk_s2;
    st_nxt.cs_s1   = spi_cs_b;
    st_nxt.cs_s2   = st_r.cs_s1;
    st_nxt.cs_q    = st_r.cs_s2;
    st_nxt.mosi_s1 = spi_mosi;
    st_nxt.mosi_s2 = st_r.mosi_s1;
    st_nxt.force_fs = 1'b0;

    // Serial engine, least significant bit first, mode 0.
    if (st_r.cs_s2) begin
      st_nxt.miso_oe = 1'b0;
    end
    if (cs_start) begin
      st_nxt.bit_cnt = 5'h00;
      st_nxt.tx_sh   = 8'h00;
      st_nxt.miso    = 1'b0;
      st_nxt.miso_oe = 1'b1;
    end
    if (sclk_rise) begin
      st_nxt.rx_sh = rx_next;
      if (st_r.bit_cnt != BIT_CNT_OVER) begin
        st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
      end
      // Contents are captured as the address completes, so a read
      // returns them in the same frame and never changes them.
      if (st_r.bit_cnt == BIT_CNT_ADDR) begin
        st_nxt.tx_sh = rd_byte(st_r, rx_next[14:8]);
      end
    end
    if (sclk_fall) begin
      st_nxt.miso  = st_r.tx_sh[0];
      st_nxt.tx_sh = {1'b0, st_r.tx_sh[7:1]};
    end

    // Command execution at the end of a frame.
    if (frame_ok && f_rw) begin
      case (f_addr)
        ADDR_WAKE_TIMER: begin
          st_nxt.period = wake_period_t'(f_data[2:0]);
        end
        ADDR_SCRATCH: begin
          if (sbc_mode == MODE_NORMAL || sbc_mode == MODE_STOP) begin
            st_nxt.scratch_value = f_data;
          end
        end
        ADDR_SUPPLY: begin
          clr_sup = 1'b1;
        end
        ADDR_THERMAL: begin
          clr_th = 1'b1;
        end
        ADDR_DEVICE: begin
          clr_dev = 1'b1;
        end
        default: begin
          clr_sup = 1'b0;
        end
      endcase
    end

    // Supply flags, gated by the state of each supply except the main rail high flag.
    sup_set[SUP_LIN_LOW]    = lin_supply_low & lin_active;
    sup_set[SUP_MAIN_HIGH]  = main_rail_high;
    sup_set[SUP_AUX_HOT]    = aux_rail_hot & aux_rail_on;
    sup_set[SUP_AUX_LOW]    = aux_rail_low & aux_rail_on;
    sup_set[SUP_MAIN_SHORT] = main_rail_shorted & main_rail_on;
    sup_set[SUP_MAIN_LOW]   = main_rail_low & main_rail_on;
    // A new event in the clearing cycle survives the clear.
    st_nxt.supply = ((clr_sup ? 8'h00 : st_r.supply) | sup_set)
                    & SUPPLY_MASK;
    st_nxt.thermal = (clr_th ? THERMAL_RST : st_r.thermal) |
                     {thermal_stage_two, thermal_stage_one,
                      thermal_prewarn};
    st_nxt.thermal_stage_two_q   = thermal_stage_two;
    st_nxt.force_fs = thermal_stage_two & ~st_r.thermal_stage_two_q;

    st_nxt.pin_stuck = (st_r.pin_stuck & ~clr_dev) |
                       reset_pin_stuck_high;
    st_nxt.fsi_error = (st_r.fsi_error & ~clr_dev) |
                       failsafe_input_error;
    st_nxt.fail_outputs_on = (st_r.fail_outputs_on & ~clr_dev) |
                             fail_outputs_active;
    st_nxt.bad_command = (st_r.bad_command & ~clr_dev) |
                         (cs_end && !frame_ok);

    // Restart cause.
    st_nxt.fail_pending = st_r.fail_pending | fail_now;
    if (clr_dev) begin
      st_nxt.restart_cause = CAUSE_CLEARED;
    end
    if (restart_enter) begin
      st_nxt.fail_pending = 1'b0;
      if (st_r.fail_pending || fail_now) begin
        st_nxt.restart_cause = CAUSE_FAILURE;
      end
    end
    if (wake_from_failsafe) begin
      st_nxt.restart_cause = CAUSE_FAILURE;
    end else if (wake_from_sleep && !restart_enter) begin
      st_nxt.restart_cause = CAUSE_SLEEP;
    end

    // Watchdog fail counter is not host clearable; a failure in the
    // same cycle as a good trigger is counted rather than lost.
    if (watchdog_fail) begin
      if (st_r.watchdog_fail_count != WD_CNT_MAX) begin
        st_nxt.watchdog_fail_count = st_r.watchdog_fail_count + 2'h1;
      end
    end else if (watchdog_good_trigger) begin
      st_nxt.watchdog_fail_count = WD_CNT_RST;
    end

    // Soft reset keeps the scratch byte and the power-on flag.
    if (soft_reset) begin
      st_nxt.period        = WAKE_P_10MS;
      st_nxt.supply        = st_r.supply & SUPPLY_SOFT_KEEP;
      st_nxt.thermal       = THERMAL_RST;
      st_nxt.restart_cause = CAUSE_CLEARED;
      st_nxt.pin_stuck     = 1'b0;
      st_nxt.fsi_error     = 1'b0;
      st_nxt.bad_command   = 1'b0;
      st_nxt.fail_outputs_on = 1'b0;
      st_nxt.watchdog_fail_count = WD_CNT_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign spi_miso          = st_r.miso;
  assign spi_miso_oe       = st_r.miso_oe;
  assign wake_timer_period = st_r.period;
  assign force_failsafe    = st_r.force_fs;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_write_to(logic [6:0] a);
    frame_ok && f_rw && (f_addr == a);
  endsequence

  sequence s_quiet_cycle;
    !soft_reset && !thermal_stage_two && !thermal_stage_one &&
    !thermal_prewarn;
  endsequence

  a_period_write: assert property (
    s_write_to(ADDR_WAKE_TIMER) and !soft_reset |=>
      wake_timer_period == $past(f_data[2:0])
  ) else $error("wake period not written");
  a_scratch_soft: assert property (
    soft_reset |=> st_r.scratch_value == $past(st_r.scratch_value)
  ) else $error("scratch lost on soft reset");
  a_scratch_mode: assert property (
    (sbc_mode == MODE_FAILSAFE || sbc_mode == MODE_RESTART) |=>
      $stable(st_r.scratch_value)
  ) else $error("scratch changed in fail-safe or restart");
  a_scratch_write: assert property (
    s_write_to(ADDR_SCRATCH) and (sbc_mode == MODE_NORMAL) |=>
      st_r.scratch_value == $past(f_data)
  ) else $error("scratch write lost");
  a_read_keeps: assert property (
    frame_ok && !f_rw && (st_r.thermal != 3'h0) && !soft_reset |=>
      st_r.thermal == $past(st_r.thermal)
  ) else $error("read changed thermal status");

  a_clear_thermal: assert property (
    s_write_to(ADDR_THERMAL) ##0 s_quiet_cycle |=> st_r.thermal == 3'h0
  ) else $error("thermal clear failed");
  a_main_gate: assert property (
    !main_rail_on && !st_r.supply[SUP_MAIN_LOW] |=>
      !st_r.supply[SUP_MAIN_LOW]
  ) else $error("main rail low set while off");
  a_aux_gate: assert property (
    !aux_rail_on && !st_r.supply[SUP_AUX_HOT] |=>
      !st_r.supply[SUP_AUX_HOT]
  ) else $error("aux rail hot set while off");
  a_lin_gate: assert property (
    !lin_active && !st_r.supply[SUP_LIN_LOW] |=>
      !st_r.supply[SUP_LIN_LOW]
  ) else $error("lin supply flag set while idle");

  a_failsafe_kick: assert property (
    thermal_stage_two && !st_r.thermal_stage_two_q |=>
      force_failsafe ##1 (!force_failsafe || thermal_stage_two)
  ) else $error("fail-safe not forced");

  a_cause_ov: assert property (
    restart_enter && main_rail_high && overvoltage_restart_enable &&
    !soft_reset |=> st_r.restart_cause == CAUSE_FAILURE
  ) else $error("restart cause not failure");

  a_cause_sleep: assert property (
    wake_from_sleep && !wake_from_failsafe && !restart_enter &&
    !soft_reset |=> st_r.restart_cause == CAUSE_SLEEP
  ) else $error("sleep wake cause missing");

  a_wd_range: assert property (
    st_r.watchdog_fail_count != 2'h3
  ) else $error("watchdog counter reached three");
  a_wd_clear: assert property (
    watchdog_good_trigger && !watchdog_fail |=>
      st_r.watchdog_fail_count == WD_CNT_RST
  ) else $error("watchdog counter not cleared");
  a_bad_frame: assert property (
    cs_end && (st_r.bit_cnt != BIT_CNT_FULL) && !soft_reset |=>
      st_r.bad_command && $stable(st_r.period)
  ) else $error("bad frame not flagged");

  a_reserved_zero: assert property (
    !st_r.supply[1] && (rd_byte(st_r, ADDR_THERMAL) < 8'h08)
  ) else $error("reserved bit set");

endmodule

// ---- testbench/spi_master_model.sv ----
// ----------------------------------------------------------------
// Serial host model
// ----------------------------------------------------------------
// Mode 0 master: the serial clock idles low and stands still between frames.
// Each phase lasts five system clocks, so the design's two-stage synchronisers
// never miss an edge.
module spi_master_model (
  input  wire logic clk,
  output logic      spi_clk,
  output logic      spi_cs_b,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    spi_clk  = 1'b0;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
  end

  // Sends nbits of tx, least significant bit first, and gathers the reply.
  // A reply bit seen while the output is not enabled comes back unknown.
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    int i;
    rx = '0;
    @(posedge clk);
    #1 spi_cs_b = 1'b0;
    spi_mosi = tx[0];
    repeat (4) @(posedge clk);
    for (i = 0; i < nbits; i++) begin
      repeat (5) @(posedge clk);
      #1 rx[i] = spi_miso_oe ? spi_miso : 1'bx;
      spi_clk = 1'b1;
      repeat (5) @(posedge clk);
      #1 spi_clk = 1'b0;
      if (i + 1 < nbits) begin
        spi_mosi = tx[i+1];
      end
    end
    repeat (4) @(posedge clk);
    #1 spi_cs_b = 1'b1;
    // The released data line must not keep showing its last bit.
    spi_mosi = ~spi_mosi;
    repeat (8) @(posedge clk);
    // Hand back just after the edge so the caller's next drive never races it.
    #1;
  endtask
endmodule

// ---- testbench/sbc_status_register_bank_tb_top.sv ----
`define CHK(nm, exp, got) \
  begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module sbc_status_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sbc_regs_pkg::*;

  logic                clk;
  logic                rst_b;
  logic                spi_clk;
  logic                spi_cs_b;
  logic                spi_mosi;
  logic                spi_miso;
  logic                spi_miso_oe;
  mode_t               mode;
  logic [17:0]         ev;
  logic                main_on;
  logic                aux_on;
  logic                lin_on;
  logic                ov_en;
  wake_period_t        period;
  logic                force_fs;
  int                  n_mismatch;
  int                  checks_done;
  int                  cyc;
  int                  fs_cnt;
  logic [15:0]         rx;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  sbc_status_register_bank i_sbc_status_register_bank (
    .clk                        (clk),
    .rst_b                      (rst_b),
    .spi_clk                    (spi_clk),
    .spi_cs_b                   (spi_cs_b),
    .spi_mosi                   (spi_mosi),
    .spi_miso                   (spi_miso),
    .spi_miso_oe                (spi_miso_oe),
    .sbc_mode                   (mode),
    .soft_reset                 (ev[14]),
    .restart_enter              (ev[15]),
    .wake_from_sleep            (ev[16]),
    .wake_from_failsafe         (ev[17]),
    .main_rail_on               (main_on),
    .aux_rail_on                (aux_on),
    .lin_active                 (lin_on),
    .main_rail_low              (ev[0]),
    .main_rail_shorted          (ev[1]),
    .main_rail_high             (ev[2]),
    .aux_rail_low               (ev[3]),
    .aux_rail_hot               (ev[4]),
    .lin_supply_low             (ev[5]),
    .thermal_stage_two          (ev[6]),
    .thermal_stage_one          (ev[7]),
    .thermal_prewarn            (ev[8]),
    .reset_pin_stuck_high       (ev[9]),
    .failsafe_input_error       (ev[10]),
    .watchdog_fail              (ev[11]),
    .watchdog_good_trigger      (ev[12]),
    .fail_outputs_active        (ev[13]),
    .overvoltage_restart_enable (ov_en),
    .wake_timer_period          (period),
    .force_failsafe             (force_fs)
  );

  spi_master_model i_spi_master_model (
    .clk         (clk),
    .spi_clk     (spi_clk),
    .spi_cs_b    (spi_cs_b),
    .spi_mosi    (spi_mosi),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe)
  );

  // ----------------------------------------------------------------
  // Run guard and verdict
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // The full sequence needs about 11000 cycles; reaching 30000 means a hang.
  always @(posedge clk) begin
    cyc++;
    fs_cnt += (force_fs === 1'b1) ? 1 : 0;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    i_spi_master_model.xfer({8'h00, 1'b0, a}, 16, rx);
    `CHK("read low byte", 8'h00, rx[7:0])
    `CHK("read data", exp, rx[15:8])
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_spi_master_model.xfer({d, 1'b1, a}, 16, rx);
  endtask

  task automatic pulse(input int idx);
    @(posedge clk);
    #1 ev[idx] = 1'b1;
    @(posedge clk);
    #1 ev[idx] = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    rst_b = 1'b0;
    mode = MODE_NORMAL;
    ev = '0;
    main_on = 1'b0;
    aux_on = 1'b0;
    lin_on = 1'b0;
    ov_en = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    cyc = 0;
    fs_cnt = 0;
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (5) @(posedge clk);
    // Power-on values.
    rd(ADDR_WAKE_TIMER, 8'h00);
    rd(ADDR_SCRATCH, 8'h00);
    rd(ADDR_SUPPLY, 8'h80);
    rd(ADDR_THERMAL, 8'h00);
    rd(ADDR_DEVICE, 8'h00);
    // Every period code, reserved one included.
    for (k = 0; k < 8; k++) begin
      wr(ADDR_WAKE_TIMER, 8'(k));
      `CHK("period", 3'(k), period)
      rd(ADDR_WAKE_TIMER, 8'(k));
    end
    // Scratch byte survives soft reset, restart and fail-safe.
    wr(ADDR_SCRATCH, 8'ha5);
    pulse(14);
    rd(ADDR_SCRATCH, 8'ha5);
    rd(ADDR_WAKE_TIMER, 8'h00);
    rd(ADDR_SUPPLY, 8'h80);
    mode = MODE_FAILSAFE;
    wr(ADDR_SCRATCH, 8'h3c);
    rd(ADDR_SCRATCH, 8'ha5);
    mode = MODE_RESTART;
    pulse(15);
    rd(ADDR_SCRATCH, 8'ha5);
    mode = MODE_STOP;
    wr(ADDR_SCRATCH, 8'h3c);
    rd(ADDR_SCRATCH, 8'h3c);
    mode = MODE_NORMAL;
    // Supply flags: all but main high blocked while rails are off, latched once on.
    wr(ADDR_SUPPLY, 8'h00);
    for (k = 0; k < 6; k++) pulse(k);
    rd(ADDR_SUPPLY, 8'h20);
    main_on = 1'b1;
    aux_on = 1'b1;
    lin_on = 1'b1;
    for (k = 0; k < 6; k++) pulse(k);
    rd(ADDR_SUPPLY, 8'h7d);
    wr(ADDR_SUPPLY, 8'hff);
    rd(ADDR_SUPPLY, 8'h00);
    // Thermal flags and the fail-safe request.
    for (k = 6; k < 9; k++) pulse(k);
    rd(ADDR_THERMAL, 8'h07);
    rd(ADDR_THERMAL, 8'h07);
    `CHK("failsafe pulses", 1, fs_cnt)
    wr(ADDR_THERMAL, 8'h00);
    rd(ADDR_THERMAL, 8'h00);
    // Device flags and the saturating watchdog counter.
    for (k = 9; k < 11; k++) pulse(k);
    pulse(13);
    pulse(11);
    rd(ADDR_DEVICE, 8'h35);
    pulse(11);
    pulse(11);
    rd(ADDR_DEVICE, 8'h39);
    wr(ADDR_DEVICE, 8'h00);
    rd(ADDR_DEVICE, 8'h08);
    pulse(12);
    rd(ADDR_DEVICE, 8'h00);
    // Unmapped address and short frame are refused and flagged.
    wr(7'h10, 8'h55);
    rd(ADDR_DEVICE, 8'h02);
    wr(ADDR_DEVICE, 8'h00);
    i_spi_master_model.xfer({8'h03, 1'b1, ADDR_WAKE_TIMER}, 8, rx);
    rd(ADDR_DEVICE, 8'h02);
    rd(ADDR_WAKE_TIMER, 8'h00);
    // Restart cause codes.
    pulse(15);
    wr(ADDR_DEVICE, 8'h00);
    pulse(15);
    rd(ADDR_DEVICE, 8'h00);
    pulse(2);
    pulse(15);
    rd(ADDR_DEVICE, 8'h00);
    ov_en = 1'b1;
    pulse(2);
    pulse(15);
    rd(ADDR_DEVICE, 8'h40);
    // Overvoltage seen in the very cycle of the restart counts as well.
    wr(ADDR_DEVICE, 8'h00);
    @(posedge clk);
    #1 {ev[15], ev[2]} = 2'b11;
    @(posedge clk);
    #1 {ev[15], ev[2]} = 2'b00;
    rd(ADDR_DEVICE, 8'h40);
    wr(ADDR_DEVICE, 8'h00);
    pulse(11);
    pulse(15);
    rd(ADDR_DEVICE, 8'h44);
    wr(ADDR_DEVICE, 8'h00);
    pulse(12);
    pulse(16);
    rd(ADDR_DEVICE, 8'h80);
    wr(ADDR_DEVICE, 8'h00);
    pulse(17);
    rd(ADDR_DEVICE, 8'h40);
    final_report();
  end
endmodule
